// File: hdl/dmq_delay_counter.sv
//==========================================================================
// Down-counter that reports busy until a loaded count has expired.
//==========================================================================
module dmq_delay_counter (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [7:0] loadValue,
   output logic busy
);
   logic [7:0] count;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 8'h00;
      end else if (load) begin
         count <= loadValue;
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= load ? (loadValue != 8'h00) : (count > 8'h01);
      end
   end
endmodule

// File: hdl/dram_mode_command_qualifier.sv
//==========================================================================
// Command-side qualifier: parity checking, low-power fallback, per-device
// mode-register writes and data reference training fields.
//==========================================================================
module dram_mode_command_qualifier (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire dmq_pkg::dmq_cmd_bus_t cmdIn,
   input wire logic dataBitZero,
   input wire logic dataStrobe,
   input wire logic odtPin,
   input wire logic [7:0] additiveLatency,
   input wire logic [7:0] writeLatency,
   input wire logic statusClearValid,
   input wire logic statusClearValue,
   input wire logic queuesDrained,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_address,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic alert_n,
   output logic parityErrorStatus,
   output logic precharge_all,
   output logic modeWriteStrobe,
   output logic [2:0] modeWriteIndex,
   output logic [17:0] modeWriteData,
   output logic perDeviceAddressing,
   output dmq_pkg::dmq_pwr_t powerState,
   output logic terminationOn,
   output logic vrefCalEnable,
   output logic vrefRange,
   output logic [5:0] vrefLevel,
   output logic vrefValid,
   output logic modeDelayBusy,
   output logic [7:0] modeDelayCycles
);
   // =======================================================================
   // Register map.
   // =======================================================================
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h1;
   localparam logic [3:0] REG_VREF = 4'h2;

   // =======================================================================
   // Pin synchronisers: three stages, change accepted when 2 and 3 agree.
   // =======================================================================
   logic [2:0] dqSync;
   logic [2:0] dqsSync;
   logic [2:0] odtSync;
   logic dqStable;
   logic dqsStable;
   logic odtStable;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqSync <= 3'h0;
         dqsSync <= 3'h0;
         odtSync <= 3'h0;
      end else begin
         dqSync <= {dqSync[1:0], dataBitZero};
         dqsSync <= {dqsSync[1:0], dataStrobe};
         odtSync <= {odtSync[1:0], odtPin};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqStable <= 1'b0;
         dqsStable <= 1'b0;
         odtStable <= 1'b0;
      end else begin
         if (dqSync[1] == dqSync[2]) begin
            dqStable <= dqSync[2];
         end
         if (dqsSync[1] == dqsSync[2]) begin
            dqsStable <= dqsSync[2];
         end
         if (odtSync[1] == odtSync[2]) begin
            odtStable <= odtSync[2];
         end
      end
   end

   // =======================================================================
   // Parity check and error handling.
   // =======================================================================
   logic [6:0] parityLatency;
   logic persistMode;
   logic checkEnable;
   logic parityError;
   logic [7:0] alertCount;
   dmq_pkg::dmq_err_t errState;
   logic statusSet;
   logic swClear;

   // Even parity over bank group, bank, address and the parity pin.
   assign parityError = cmdIn.valid && (parityLatency != 7'h00) &&
      checkEnable && (^{cmdIn.bankGroup, cmdIn.bank, cmdIn.addr,
      cmdIn.parity});

   // Resuming in persistent mode ignores the status bit.
   assign checkEnable = (errState == dmq_pkg::DMQ_ERR_IDLE) &&
      (persistMode || !parityErrorStatus);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         errState <= dmq_pkg::DMQ_ERR_IDLE;
         alertCount <= 8'h00;
      end else begin
         unique case (errState)
            dmq_pkg::DMQ_ERR_IDLE: begin
               if (parityError) begin
                  errState <= dmq_pkg::DMQ_ERR_ALERT;
                  alertCount <= dmq_pkg::ALERT_PW_CYC;
               end
            end
            dmq_pkg::DMQ_ERR_ALERT: begin
               // Alert stays until the pulse ends and queues are empty.
               if (alertCount != 8'h00) begin
                  alertCount <= alertCount - 8'h01;
               end else if (queuesDrained) begin
                  errState <= dmq_pkg::DMQ_ERR_IDLE;
               end
            end
            dmq_pkg::DMQ_ERR_HOLD: begin
               errState <= dmq_pkg::DMQ_ERR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_n <= 1'b1;
         precharge_all <= 1'b0;
      end else begin
         alert_n <= !(parityError || errState == dmq_pkg::DMQ_ERR_ALERT);
         precharge_all <= parityError;
      end
   end

   // Software may only clear the status; a write of one is blocked.
   assign statusSet = parityError;
   assign swClear = (statusClearValid && !statusClearValue) ||
      (avs_write && avs_waitrequest && avs_address == REG_STATUS &&
      !avs_writedata[0]);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         parityErrorStatus <= 1'b0;
      end else if (statusSet) begin
         parityErrorStatus <= 1'b1;
      end else if (swClear) begin
         parityErrorStatus <= 1'b0;
      end
   end

   // =======================================================================
   // Power state: a self-refresh entry with an error lands in power-down.
   // =======================================================================
   logic cmdOk;
   assign cmdOk = cmdIn.valid && !parityError;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         powerState <= dmq_pkg::DMQ_PWR_ACTIVE;
      end else if (cmdIn.valid && cmdIn.cmd == dmq_pkg::DMQ_CMD_SRE) begin
         powerState <= parityError ? dmq_pkg::DMQ_PWR_POWER_DOWN :
            dmq_pkg::DMQ_PWR_SELF_REFRESH;
      end else if (cmdOk && cmdIn.cmd == dmq_pkg::DMQ_CMD_PDE) begin
         powerState <= dmq_pkg::DMQ_PWR_POWER_DOWN;
      end else if (cmdOk && (cmdIn.cmd == dmq_pkg::DMQ_CMD_SRX ||
            cmdIn.cmd == dmq_pkg::DMQ_CMD_PDX)) begin
         powerState <= dmq_pkg::DMQ_PWR_ACTIVE;
      end
   end

   // =======================================================================
   // Mode-register writes with per-device qualification.
   // =======================================================================
   logic pending;
   logic [7:0] waitCount;
   logic [2:0] pendIndex;
   logic [17:0] pendData;
   logic strobeSeen;
   logic dqsPrev;
   logic isMrs;
   logic sampleNow;
   logic execWrite;

   assign isMrs = cmdOk && cmdIn.cmd == dmq_pkg::DMQ_CMD_MRS;
   assign sampleNow = pending && waitCount == 8'h00 &&
      (strobeSeen || (dqsStable != dqsPrev));
   // Low data bit zero executes, high ignores the write.
   assign execWrite = sampleNow && !dqStable;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         waitCount <= 8'h00;
         pendIndex <= 3'h0;
         pendData <= dmq_pkg::MR_RESET;
         strobeSeen <= 1'b0;
         dqsPrev <= 1'b0;
      end else begin
         dqsPrev <= dqsStable;
         if (isMrs && perDeviceAddressing && !pending) begin
            pending <= 1'b1;
            // Qualifier lands where write data would.
            waitCount <= additiveLatency + writeLatency +
               dmq_pkg::DQ0_SAMPLE_OFFSET;
            pendIndex <= {cmdIn.bank[0], cmdIn.bankGroup};
            pendData <= cmdIn.addr;
            strobeSeen <= 1'b0;
         end else if (pending) begin
            if (waitCount != 8'h00) begin
               waitCount <= waitCount - 8'h01;
            end else if (sampleNow) begin
               pending <= 1'b0;
            end else if (dqsStable != dqsPrev) begin
               strobeSeen <= 1'b1;
            end
         end
      end
   end

   logic directWrite;
   logic [2:0] wrIndex;
   logic [17:0] wrData;
   assign directWrite = isMrs && !perDeviceAddressing;
   assign wrIndex = directWrite ? {cmdIn.bank[0], cmdIn.bankGroup} :
      pendIndex;
   assign wrData = directWrite ? cmdIn.addr : pendData;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeWriteStrobe <= 1'b0;
         modeWriteIndex <= 3'h0;
         modeWriteData <= dmq_pkg::MR_RESET;
      end else begin
         modeWriteStrobe <= directWrite || execWrite;
         modeWriteIndex <= wrIndex;
         modeWriteData <= wrData;
      end
   end

   logic doWrite;
   assign doWrite = directWrite || execWrite;

   // A write to MR3 reprograms the whole register, and bit 4 with it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         perDeviceAddressing <= 1'b0;
      end else if (doWrite && wrIndex == dmq_pkg::MR_IDX_MR3) begin
         perDeviceAddressing <= wrData[dmq_pkg::MR3_PDA_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         parityLatency <= 7'h00;
         persistMode <= 1'b0;
      end else if (doWrite && wrIndex == dmq_pkg::MR_IDX_MR5) begin
         persistMode <= wrData[dmq_pkg::MR5_PERSIST_BIT];
         // Latency may change only through the disabled state.
         if (parityLatency == 7'h00 ||
               wrData[dmq_pkg::MR5_PL_LSB +: 3] == 3'h0) begin
            parityLatency <= {4'h0, wrData[dmq_pkg::MR5_PL_LSB +: 3]};
         end
      end
   end

   // =======================================================================
   // Data reference training fields.
   // =======================================================================
   logic mr6Write;
   assign mr6Write = doWrite && wrIndex == dmq_pkg::MR_IDX_MR6;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vrefCalEnable <= 1'b0;
         vrefRange <= 1'b0;
         vrefLevel <= dmq_pkg::VREF_LEVEL_RESET;
      end else if (mr6Write) begin
         vrefCalEnable <= wrData[dmq_pkg::MR6_CAL_EN_BIT];
         if (wrData[dmq_pkg::MR6_CAL_EN_BIT]) begin
            vrefRange <= wrData[dmq_pkg::MR6_RANGE_BIT];
            vrefLevel <= wrData[dmq_pkg::MR6_LEVEL_MSB:0];
         end
      end
   end

   // Undefined after reset until the first programmed level settles.
   logic vrefBusy;
   logic vrefProgrammed;
   dmq_delay_counter vrefTimer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(mr6Write && wrData[dmq_pkg::MR6_CAL_EN_BIT]),
      .loadValue(dmq_pkg::VREF_TIME_CYC),
      .busy(vrefBusy)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vrefProgrammed <= 1'b0;
         vrefValid <= 1'b0;
      end else begin
         if (mr6Write && wrData[dmq_pkg::MR6_CAL_EN_BIT]) begin
            vrefProgrammed <= 1'b1;
         end
         vrefValid <= vrefProgrammed && !vrefBusy;
      end
   end

   // =======================================================================
   // Mode delay with parity latency and termination.
   // =======================================================================
   logic [7:0] modeDelay;
   logic modeBusy;
   assign modeDelay = dmq_pkg::TMOD_CYC + {1'b0, parityLatency};

   dmq_delay_counter modeTimer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(doWrite),
      .loadValue(modeDelay),
      .busy(modeBusy)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeDelayBusy <= 1'b0;
         modeDelayCycles <= 8'h00;
         terminationOn <= 1'b0;
      end else begin
         modeDelayBusy <= modeBusy;
         modeDelayCycles <= modeDelay;
         // No dynamic switching: the pin drives termination directly.
         terminationOn <= odtStable;
      end
   end

   // =======================================================================
   // Avalon-MM slave: one wait cycle, then the answer.
   // =======================================================================
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         unique case (avs_address)
            REG_STATUS: avs_readdata <= {29'h0, alert_n, persistMode,
               parityErrorStatus};
            REG_MODE: avs_readdata <= {24'h0, modeDelayBusy,
               perDeviceAddressing, powerState, 1'b0, parityLatency[2:0]};
            REG_VREF: avs_readdata <= {23'h0, vrefValid, vrefCalEnable,
               vrefRange, vrefLevel};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// File: shared/dmq_pkg.sv
//==========================================================================
//==========================================================================
package dmq_pkg;
   // Command field carried from the command decoder.
   typedef enum logic [2:0] {
      DMQ_CMD_DES = 3'h0,
      DMQ_CMD_MRS = 3'h1,
      DMQ_CMD_SRE = 3'h2,
      DMQ_CMD_SRX = 3'h3,
      DMQ_CMD_PDE = 3'h4,
      DMQ_CMD_PDX = 3'h5,
      DMQ_CMD_OTHER = 3'h6
   } dmq_cmd_t;

   typedef struct packed {
      logic valid;
      dmq_cmd_t cmd;
      logic [1:0] bankGroup;
      logic [1:0] bank;
      logic [17:0] addr;
      logic parity;
   } dmq_cmd_bus_t;

   typedef enum logic [1:0] {
      DMQ_PWR_ACTIVE = 2'h0,
      DMQ_PWR_SELF_REFRESH = 2'h1,
      DMQ_PWR_POWER_DOWN = 2'h2
   } dmq_pwr_t;

   typedef enum logic [1:0] {
      DMQ_ERR_IDLE = 2'h0,
      DMQ_ERR_ALERT = 2'h1,
      DMQ_ERR_HOLD = 2'h2
   } dmq_err_t;

   // Mode register indices and field positions.
   localparam logic [2:0] MR_IDX_MR3 = 3'h3;
   localparam logic [2:0] MR_IDX_MR5 = 3'h5;
   localparam logic [2:0] MR_IDX_MR6 = 3'h6;
   localparam int MR3_PDA_BIT = 4;
   localparam int MR5_PERSIST_BIT = 9;
   localparam int MR5_PL_LSB = 0;
   localparam int MR6_CAL_EN_BIT = 7;
   localparam int MR6_RANGE_BIT = 6;
   localparam int MR6_LEVEL_MSB = 5;

   // Reset values.
   localparam logic [17:0] MR_RESET = 18'h00000;
   localparam logic [5:0] VREF_LEVEL_RESET = 6'h00;

   // Timing, in nanoseconds and in clock cycles of core_clk.
   localparam int CLK_PERIOD_NS = 10;
   localparam int ALERT_PW_NS = 640;
   localparam logic [7:0] ALERT_PW_CYC =
      8'((ALERT_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] TMOD_CYC = 8'h18;
   localparam int VREF_TIME_NS = 150;
   localparam logic [7:0] VREF_TIME_CYC =
      8'((VREF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DQ0_SAMPLE_OFFSET = 8'h01;
endpackage

// File: tb/dmq_ctrl_model.sv
module dmq_ctrl_model (
   input wire logic core_clk,
   output dmq_pkg::dmq_cmd_bus_t cmdIn,
   output logic dataBitZero,
   output logic dataStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmdIn = '0;
      dataBitZero = 1'b1;
      dataStrobe = 1'b0;
   end
   // A set flip inverts the even parity to force an error.
   task automatic send(input dmq_pkg::dmq_cmd_t c, input logic [2:0] idx,
      input logic [17:0] a, input logic flip);
      dmq_pkg::dmq_cmd_bus_t b;
      b.valid = 1'b1;
      b.cmd = c;
      b.bankGroup = idx[1:0];
      b.bank = {1'b0, idx[2]};
      b.addr = a;
      b.parity = (^{idx, a}) ^ flip;
      @(posedge core_clk);
      cmdIn <= b;
      b.valid = 1'b0;
      b.cmd = dmq_pkg::DMQ_CMD_DES;
      b.addr = ~a;
      @(posedge core_clk);
      cmdIn <= b;
   endtask
   // The qualifier bit is held from the command to the end of the burst.
   task automatic pda_write(input logic [2:0] idx, input logic [17:0] a,
      input logic dq, input int beats, input int lat);
      @(posedge core_clk);
      dataBitZero <= dq;
      send(dmq_pkg::DMQ_CMD_MRS, idx, a, 1'b0);
      repeat (lat - 1) @(posedge core_clk);
      // Each strobe level stands two cycles so the pin filter accepts it.
      repeat (beats) begin
         repeat (2) @(posedge core_clk);
         dataStrobe <= ~dataStrobe;
      end
      @(posedge core_clk);
      dataBitZero <= ~dq;
   endtask
endmodule

// File: tb/dmq_qualifier_checker.sv
module dmq_qualifier_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire dmq_pkg::dmq_cmd_bus_t cmdIn,
   input wire logic queuesDrained,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic alert_n,
   input wire logic parityErrorStatus,
   input wire logic precharge_all,
   input wire logic modeWriteStrobe,
   input wire logic perDeviceAddressing,
   input wire dmq_pkg::dmq_pwr_t powerState,
   input wire logic [5:0] vrefLevel,
   input wire logic vrefValid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic badCmd;
   logic sreCmd;
   logic [7:0] lowCount;
   assign badCmd = cmdIn.valid &
      (^{cmdIn.bankGroup, cmdIn.bank, cmdIn.addr, cmdIn.parity});
   assign sreCmd = cmdIn.valid & (cmdIn.cmd == dmq_pkg::DMQ_CMD_SRE);
   // Saturates so a stuck alert cannot wrap and look short.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) lowCount <= 8'h00;
      else if (alert_n) lowCount <= 8'h00;
      else if (lowCount != 8'hFF) lowCount <= lowCount + 8'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   //=======================================================================
   // Sequences and properties
   sequence s_precharge_pulse;
      precharge_all ##1 !precharge_all;
   endsequence
   sequence s_vref_settle;
      !vrefValid[*7] ##[1:12] vrefValid;
   endsequence
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_bus_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_alert_cause;
      $fell(alert_n) |-> $past(badCmd);
   endproperty
   property p_alert_width;
      $rose(alert_n) |-> lowCount >= dmq_pkg::ALERT_PW_CYC;
   endproperty
   property p_alert_release;
      $fell(alert_n) && queuesDrained |-> ##[60:100] alert_n;
   endproperty
   property p_precharge;
      $fell(alert_n) |-> s_precharge_pulse;
   endproperty
   property p_status;
      $rose(alert_n) |-> parityErrorStatus;
   endproperty
   property p_sre_fallback;
      $fell(alert_n) && $past(sreCmd) |->
         ##[0:3] powerState == dmq_pkg::DMQ_PWR_POWER_DOWN;
   endproperty
   property p_pda_on;
      $rose(perDeviceAddressing) |-> modeWriteStrobe || $past(modeWriteStrobe);
   endproperty
   property p_vref_step;
      $changed(vrefLevel) |-> ##1 s_vref_settle;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("waitrequest did not drop after a request");
   a_bus_one: assert property (p_bus_one)
      else $error("waitrequest stayed low");
   a_alert_cause: assert property (p_alert_cause)
      else $error("alert without an odd parity command");
   a_alert_width: assert property (p_alert_width)
      else $error("alert pulse too short");
   a_alert_release: assert property (p_alert_release)
      else $error("alert not released in time");
   a_precharge: assert property (p_precharge)
      else $error("no precharge pulse on parity error");
   a_status: assert property (p_status)
      else $error("status not set when alert released");
   a_sre_fallback: assert property (p_sre_fallback)
      else $error("failed entry did not fall back to power down");
   a_pda_on: assert property (p_pda_on)
      else $error("per device mode set without a mode write");
   a_vref_step: assert property (p_vref_step)
      else $error("reference valid too early or never");
endmodule

// File: tb/test_dram_mode_command_qualifier.sv
module test_dram_mode_command_qualifier;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [17:0] addr;
      logic [31:0] vref;
   } dmq_row_t;
   localparam int AL = 2;
   localparam int WL = 9;
   logic core_clk, rst_n, odtPin, queuesDrained;
   logic statusClearValid, statusClearValue, avs_read, avs_write;
   logic [7:0] additiveLatency, writeLatency, modeDelayCycles;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic avs_waitrequest, alert_n, parityErrorStatus, precharge_all;
   logic modeWriteStrobe, perDeviceAddressing, terminationOn;
   logic vrefCalEnable, vrefRange, vrefValid, modeDelayBusy;
   logic [2:0] modeWriteIndex;
   logic [17:0] modeWriteData;
   logic [5:0] vrefLevel;
   logic dataBitZero, dataStrobe;
   dmq_pkg::dmq_cmd_bus_t cmdIn;
   dmq_pkg::dmq_pwr_t powerState;
   int errors = 0;
   int n_compared = 0;
   dmq_row_t rows [3] = '{'{18'h000C5, 32'h1C5}, '{18'h0004A, 32'h145},
      '{18'h0008A, 32'h18A}};
   dram_mode_command_qualifier dut (.core_clk(core_clk), .rst_n(rst_n),
      .cmdIn(cmdIn), .dataBitZero(dataBitZero), .dataStrobe(dataStrobe),
      .odtPin(odtPin), .additiveLatency(additiveLatency),
      .writeLatency(writeLatency), .statusClearValid(statusClearValid),
      .statusClearValue(statusClearValue), .queuesDrained(queuesDrained),
      .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .alert_n(alert_n),
      .parityErrorStatus(parityErrorStatus), .precharge_all(precharge_all),
      .modeWriteStrobe(modeWriteStrobe), .modeWriteIndex(modeWriteIndex),
      .modeWriteData(modeWriteData), .perDeviceAddressing(perDeviceAddressing),
      .powerState(powerState), .terminationOn(terminationOn),
      .vrefCalEnable(vrefCalEnable), .vrefRange(vrefRange),
      .vrefLevel(vrefLevel), .vrefValid(vrefValid),
      .modeDelayBusy(modeDelayBusy), .modeDelayCycles(modeDelayCycles));
   dmq_ctrl_model ctl (.core_clk(core_clk), .cmdIn(cmdIn),
      .dataBitZero(dataBitZero), .dataStrobe(dataStrobe));
   //=======================================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // The request is held until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      check("bus answer", 32'h0, {31'h0, avs_waitrequest});
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   //=======================================================================
   // Clock, watchdog and main sequence
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      idle(6000);
      errors++;
      stop_test();
   end
   initial begin
      logic [31:0] q;
      rst_n = 1'b0;
      odtPin = 1'b0;
      queuesDrained = 1'b1;
      statusClearValid = 1'b0;
      statusClearValue = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      additiveLatency = 8'(AL);
      writeLatency = 8'(WL);
      idle(2);
      rst_n <= 1'b1;
      @(posedge core_clk);
      check("alert at reset", 32'h1, alert_n);
      check("pda at reset", 32'h0, perDeviceAddressing);
      check("power at reset", 32'h0, powerState);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 4'(i), 32'h0, q);
         check("reset read", (i == 0) ? 32'h4 : 32'h0, q);
      end
      ctl.send(dmq_pkg::DMQ_CMD_MRS, 3'h1, 18'h00100, 1'b0);
      idle(30);
      foreach (rows[i]) begin
         ctl.send(dmq_pkg::DMQ_CMD_MRS, 3'h6, rows[i].addr, 1'b0);
         idle(30);
         check("cal enable", 32'(rows[i].vref[7]), vrefCalEnable);
         check("range", 32'(rows[i].vref[6]), vrefRange);
         check("level", 32'(rows[i].vref[5:0]), vrefLevel);
         bus(1'b0, 4'h2, 32'h0, q);
         check("vref reg", rows[i].vref, q);
      end
      ctl.send(dmq_pkg::DMQ_CMD_MRS, 3'h5, 18'h00004, 1'b0);
      idle(3);
      check("mode delay", 32'(dmq_pkg::TMOD_CYC + 8'h04), modeDelayCycles);
      idle(30);
      ctl.send(dmq_pkg::DMQ_CMD_SRE, 3'h0, 18'h00000, 1'b0);
      idle(4);
      check("self refresh", 32'h1, powerState);
      ctl.send(dmq_pkg::DMQ_CMD_SRX, 3'h0, 18'h00000, 1'b0);
      idle(30);
      ctl.send(dmq_pkg::DMQ_CMD_SRE, 3'h0, 18'h00000, 1'b1);
      idle(4);
      check("alert", 32'h0, alert_n);
      check("fallback", 32'h2, powerState);
      idle(90);
      check("status", 32'h1, parityErrorStatus);
      ctl.send(dmq_pkg::DMQ_CMD_PDX, 3'h0, 18'h00000, 1'b0);
      idle(30);
      ctl.send(dmq_pkg::DMQ_CMD_OTHER, 3'h0, 18'h00123, 1'b1);
      idle(4);
      check("checking held off", 32'h1, alert_n);
      @(posedge core_clk);
      statusClearValid <= 1'b1;
      @(posedge core_clk);
      statusClearValid <= 1'b0;
      idle(3);
      check("status cleared", 32'h0, parityErrorStatus);
      ctl.send(dmq_pkg::DMQ_CMD_MRS, 3'h5, 18'h00204, 1'b0);
      idle(30);
      ctl.send(dmq_pkg::DMQ_CMD_OTHER, 3'h0, 18'h00123, 1'b1);
      idle(90);
      ctl.send(dmq_pkg::DMQ_CMD_OTHER, 3'h0, 18'h00123, 1'b1);
      idle(4);
      check("persistent alert", 32'h0, alert_n);
      idle(90);
      bus(1'b1, 4'h0, 32'h0, q);
      idle(2);
      check("bus clear", 32'h0, parityErrorStatus);
      ctl.send(dmq_pkg::DMQ_CMD_MRS, 3'h3, 18'h00010, 1'b0);
      idle(40);
      check("pda on", 32'h1, perDeviceAddressing);
      for (int v = 1; v >= 0; v--) begin
         @(posedge core_clk);
         odtPin <= v[0];
         idle(6);
         check("termination", 32'(v), terminationOn);
      end
      // Spacing of 40 cycles covers the latencies plus the mode delay.
      ctl.pda_write(3'h6, 18'h0009F, 1'b1, 8, AL + WL);
      idle(40);
      check("ignored write", 32'h0A, vrefLevel);
      ctl.pda_write(3'h6, 18'h0009F, 1'b0, 4, AL + WL);
      idle(40);
      check("executed write", 32'h1F, vrefLevel);
      ctl.pda_write(3'h3, 18'h00000, 1'b0, 8, AL + WL);
      idle(40);
      check("pda off", 32'h0, perDeviceAddressing);
      stop_test();
   end
endmodule
bind dram_mode_command_qualifier dmq_qualifier_checker chk (
   .core_clk(core_clk), .rst_n(rst_n), .cmdIn(cmdIn),
   .queuesDrained(queuesDrained), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .alert_n(alert_n), .parityErrorStatus(parityErrorStatus),
   .precharge_all(precharge_all), .modeWriteStrobe(modeWriteStrobe),
   .perDeviceAddressing(perDeviceAddressing), .powerState(powerState),
   .vrefLevel(vrefLevel), .vrefValid(vrefValid));
